// ---- design/dbgcb_unit.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Four breakpoint slots, each enabled separately
// - Enabled slot matching address bus halts CPU
// - Byte one: slot bits 4:3, enable bit 2
// - Bytes two, three: address high, low
// - 0x14 starts mass erase, returns status
// - 0x1D stores configuration, returns status
// - 0x24 returns stored configuration
// - 0x28 returns 16-bit program counter
// - 0x34 returns status byte
// - 0x3B takes three breakpoint bytes
// - 0x44 halts CPU, returns status
// - 0x4C resumes halted CPU, returns status
// - Inject runs instruction while halted, length 1 to 3
// - 0x5C steps one instruction while halted, returns status
// - 0x65-0x67 replaces next instruction, steps, while halted
// - 0x68 returns part number then version
// - Commands one to four bytes, MSB first
// - Locked device accepts only erase, status, identity
module dbgcb_unit
  import dbgcb_pkg::*;
#(
  parameter logic [7:0] PART_NUMBER = 8'hA5,  // Arbitrary value
  parameter logic [7:0] VERSION_ID  = 8'h01,  // Arbitrary value
  parameter int         ADDR_W      = 16      // CPU code address width
) (
  clk,
  sys_rst,
  linkClk,
  linkDataIn,
  linkDataOut,
  linkDataOe_n,
  cpuAddr,
  cpuPc,
  debugLockoutBit,
  eraseDone,
  cpuHalt,
  cpuStep,
  cpuInject,
  cpuInjectLen,
  cpuInjectData,
  eraseStart,
  configByte
);
  input  wire logic              clk;             // 50 MHz clock
  input  wire logic              sys_rst;         // Synchronous reset
  input  wire logic              linkClk;         // Debug link clock
  input  wire logic              linkDataIn;      // Debug data in
  output logic                   linkDataOut;     // Debug data out
  output logic                   linkDataOe_n;    // Low while driving
  input  wire logic [ADDR_W-1:0] cpuAddr;         // CPU code address bus
  input  wire logic [15:0]       cpuPc;           // CPU program counter
  input  wire logic              debugLockoutBit; // 0 locks debug
  input  wire logic              eraseDone;       // Flash erase finished
  output logic                   cpuHalt;         // Hold CPU
  output logic                   cpuStep;         // Step pulse
  output logic                   cpuInject;       // Run supplied instruction
  output logic      [1:0]        cpuInjectLen;    // Supplied length
  output logic      [23:0]       cpuInjectData;   // Supplied bytes
  output logic                   eraseStart;      // Mass erase pulse
  output logic      [7:0]        configByte;      // Debug configuration

  // Comparators and the address bytes are sized for a 16-bit code bus
  if (ADDR_W != 16) begin : g_addr_check
    $error("ADDR_W must be 16");
  end

  // ****************************************
  // Link shifter
  // ****************************************
  logic       rxValid;            // Byte strobe
  logic [7:0] rxByte;             // Byte in
  logic       txBit;              // Reply bit
  logic       txLoad_q, txLoad_d; // Reply load
  logic [7:0] txByte_q, txByte_d; // Reply byte

  dbgcb_shifter u_shift (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .linkClk    (linkClk),
    .linkDataIn (linkDataIn),
    .txLoad     (txLoad_q),
    .txByte     (txByte_q),
    .rxValid    (rxValid),
    .rxByte     (rxByte),
    .txBit      (txBit)
  );

  // ****************************************
  // Decoder helpers
  // ****************************************
  // Number of argument bytes a command carries
  function automatic logic [1:0] argCount(input logic [7:0] c);
    if (c == CMD_SET_BRK) return 2'd3;
    if (c == CMD_WR_CFG) return 2'd1;
    if (c[7:2] == CMD_INJECT_HI || c[7:2] == CMD_REPLACE_HI) return c[1:0];
    return 2'd0;
  endfunction : argCount

  // Known command code check
  function automatic logic isKnown(input logic [7:0] c);
    return (c == CMD_ERASE) || (c == CMD_WR_CFG) || (c == CMD_RD_CFG) ||
           (c == CMD_FETCH_PC) || (c == CMD_STATUS) || (c == CMD_SET_BRK) ||
           (c == CMD_HALT) || (c == CMD_RESUME) || (c == CMD_STEP) ||
           (c == CMD_IDENTITY) ||
           ((c[7:2] == CMD_INJECT_HI || c[7:2] == CMD_REPLACE_HI) && c[1:0] != 2'b00);
  endfunction : isKnown

  // Commands still allowed while locked
  function automatic logic lockExempt(input logic [7:0] c);
    return (c == CMD_ERASE) || (c == CMD_STATUS) || (c == CMD_IDENTITY);
  endfunction : lockExempt

  // ****************************************
  // State
  // ****************************************
  dbgcb_state_type state_q, state_d;
  logic [7:0]  cmd_q, cmd_d;               // Current command
  logic [23:0] args_q, args_d;             // Argument bytes
  logic [1:0]  argLeft_q, argLeft_d;       // Arguments still due
  logic [7:0]  second_q, second_d;         // Second reply byte pending
  logic        secondPend_q, secondPend_d; // Second byte to load
  logic        replyBusy_q, replyBusy_d;   // Reply still being clocked out
  logic [15:0] brkAddr_q [NUM_SLOTS];      // Slot addresses
  logic [15:0] brkAddr_d [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] brkEn_q, brkEn_d;  // Slot enables
  logic        halt_d, step_d, inject_d, erase_d;
  logic [1:0]  injLen_d;
  logic [23:0] injData_d;
  logic [7:0]  cfg_d;
  logic        oe_d;
  logic [NUM_SLOTS-1:0] hit;               // Per-slot match
  logic [7:0]  status;                     // Status byte

  // Breakpoint comparators
  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_cmp
    assign hit[i] = brkEn_q[i] && (cpuAddr == brkAddr_q[i]);
  end

  assign status = {eraseDone, 1'b0, cpuHalt, 2'b00, debugLockoutBit, 2'b00};

  // Command sequencing, one byte at a time
  always_comb begin
    state_d      = state_q;
    cmd_d        = cmd_q;
    args_d       = args_q;
    argLeft_d    = argLeft_q;
    second_d     = second_q;
    secondPend_d = secondPend_q;
    replyBusy_d  = replyBusy_q;
    brkAddr_d    = brkAddr_q;
    brkEn_d      = brkEn_q;
    halt_d       = cpuHalt | (|hit);
    step_d       = 1'b0;
    inject_d     = 1'b0;
    erase_d      = 1'b0;
    injLen_d     = cpuInjectLen;
    injData_d    = cpuInjectData;
    cfg_d        = configByte;
    txLoad_d     = 1'b0;
    txByte_d     = txByte_q;
    oe_d         = linkDataOe_n;
    unique case (state_q)
      DBGCB_IDLE: begin
        if (rxValid && replyBusy_q) begin
          // Host clocked a reply byte out; it is never decoded as a command
          if (secondPend_q) begin
            txLoad_d     = 1'b1;
            txByte_d     = second_q;  // Second byte only after the first went out
            secondPend_d = 1'b0;
          end else begin
            replyBusy_d = 1'b0;
          end
        end else if (rxValid) begin
          oe_d  = 1'b1;  // Release line for next command
          cmd_d = rxByte;
          if (!isKnown(rxByte)) begin
            state_d = DBGCB_IDLE;
          end else if (!debugLockoutBit && !lockExempt(rxByte)) begin
            state_d = DBGCB_IDLE;
          end else if (argCount(rxByte) != 2'd0) begin
            argLeft_d = argCount(rxByte);
            state_d   = DBGCB_ARG1;
          end else begin
            state_d = DBGCB_EXEC;
          end
        end
      end
      DBGCB_ARG1, DBGCB_ARG2, DBGCB_ARG3: begin
        if (rxValid) begin
          args_d    = {args_q[15:0], rxByte};
          argLeft_d = argLeft_q - 2'd1;
          if (argLeft_q == 2'd1) state_d = DBGCB_EXEC;
          else if (state_q == DBGCB_ARG1) state_d = DBGCB_ARG2;
          else state_d = DBGCB_ARG3;
        end
      end
      DBGCB_EXEC: begin
        state_d  = DBGCB_IDLE;
        txLoad_d = 1'b1;
        oe_d     = 1'b0;
        txByte_d    = status;
        replyBusy_d = 1'b1;    // Following bytes are read-back clocks
        if (cmd_q == CMD_ERASE) begin
          erase_d = 1'b1;
        end else if (cmd_q == CMD_WR_CFG) begin
          cfg_d = args_q[7:0];
        end else if (cmd_q == CMD_RD_CFG) begin
          txByte_d = configByte;
        end else if (cmd_q == CMD_FETCH_PC) begin
          txByte_d     = cpuPc[15:8];
          second_d     = cpuPc[7:0];
          secondPend_d = 1'b1;
        end else if (cmd_q == CMD_SET_BRK) begin
          brkEn_d[args_q[16+BRK_SLOT_HI:16+BRK_SLOT_LO]]   = args_q[16+BRK_EN_BIT];
          brkAddr_d[args_q[16+BRK_SLOT_HI:16+BRK_SLOT_LO]] = args_q[15:0];
          oe_d        = 1'b1;
          txLoad_d    = 1'b0;
          replyBusy_d = 1'b0;  // No reply for this command
        end else if (cmd_q == CMD_HALT) begin
          halt_d = 1'b1;
        end else if (cmd_q == CMD_RESUME) begin
          halt_d = |hit;  // A match in this cycle still wins
        end else if (cmd_q == CMD_STEP) begin
          step_d = cpuHalt;
        end else if (cmd_q == CMD_IDENTITY) begin
          txByte_d     = PART_NUMBER;
          second_d     = VERSION_ID;
          secondPend_d = 1'b1;
        end else if (cmd_q[7:2] == CMD_INJECT_HI || cmd_q[7:2] == CMD_REPLACE_HI) begin
          // Only honoured while halted; replace also steps the counter
          inject_d  = cpuHalt;
          step_d    = cpuHalt && (cmd_q[7:2] == CMD_REPLACE_HI);
          injLen_d  = cmd_q[1:0];
          injData_d = args_q;
        end
      end
      default: state_d = DBGCB_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q       <= DBGCB_IDLE;
      cmd_q         <= 8'h00;
      args_q        <= 24'h000000;
      argLeft_q     <= 2'h0;
      second_q      <= 8'h00;
      secondPend_q  <= 1'b0;
      replyBusy_q   <= 1'b0;
      brkEn_q       <= '0;
      for (int i = 0; i < NUM_SLOTS; i++) brkAddr_q[i] <= 16'h0000;
      cpuHalt       <= 1'b0;
      cpuStep       <= 1'b0;
      cpuInject     <= 1'b0;
      cpuInjectLen  <= 2'h0;
      cpuInjectData <= 24'h000000;
      eraseStart    <= 1'b0;
      configByte    <= CFG_RESET;
      txLoad_q      <= 1'b0;
      txByte_q      <= 8'h00;
      linkDataOe_n  <= 1'b1;
      linkDataOut   <= 1'b0;
    end else begin
      state_q       <= state_d;
      cmd_q         <= cmd_d;
      args_q        <= args_d;
      argLeft_q     <= argLeft_d;
      second_q      <= second_d;
      secondPend_q  <= secondPend_d;
      replyBusy_q   <= replyBusy_d;
      brkEn_q       <= brkEn_d;
      brkAddr_q     <= brkAddr_d;
      cpuHalt       <= halt_d;
      cpuStep       <= step_d;
      cpuInject     <= inject_d;
      cpuInjectLen  <= injLen_d;
      cpuInjectData <= injData_d;
      eraseStart    <= erase_d;
      configByte    <= cfg_d;
      txLoad_q      <= txLoad_d;
      txByte_q      <= txByte_d;
      linkDataOe_n  <= oe_d;
      linkDataOut   <= txBit;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence execOf(logic [7:0] c);
    state_q == DBGCB_EXEC && cmd_q == c;
  endsequence

  brk_halt_a: assert property (|hit |=> cpuHalt) else $error("match did not halt");
  halt_cmd_a: assert property (execOf(CMD_HALT) |=> cpuHalt)
    else $error("halt command ignored");
  resume_cmd_a: assert property (state_q == DBGCB_EXEC && cmd_q == CMD_RESUME && !(|hit)
      |=> !cpuHalt) else $error("resume command ignored");
  erase_cmd_a: assert property (execOf(CMD_ERASE) |=> eraseStart ##1 !eraseStart)
    else $error("erase pulse wrong");
  // Arguments stay put through the execute cycle
  cfg_write_a: assert property (execOf(CMD_WR_CFG) |=> configByte == args_q[7:0])
    else $error("config not stored");
  lock_refuse_a: assert property (state_q == DBGCB_IDLE && rxValid && !debugLockoutBit
      && !lockExempt(rxByte) |=> state_q == DBGCB_IDLE) else $error("locked command taken");
  unknown_cmd_a: assert property (state_q == DBGCB_IDLE && rxValid && !isKnown(rxByte)
      |=> state_q == DBGCB_IDLE && $stable(brkEn_q)) else $error("unknown code acted");
  step_pulse_a: assert property (cpuStep |-> $past(cpuHalt)) else $error("step while running");
  ident_reply_a: assert property (execOf(CMD_IDENTITY) |=> txByte_q == PART_NUMBER
      && second_q == VERSION_ID && secondPend_q) else $error("identity reply wrong");
  second_byte_a: assert property (rxValid && replyBusy_q && secondPend_q
      |=> txLoad_q && state_q == DBGCB_IDLE) else $error("second reply byte lost");
  brk_args_a: assert property (state_q == DBGCB_IDLE && rxValid && !replyBusy_q
      && rxByte == CMD_SET_BRK && debugLockoutBit |=> argLeft_q == 2'd3)
      else $error("breakpoint arg count");

endmodule : dbgcb_unit

// ---- design/dbgcb_pkg.sv ----
package dbgcb_pkg;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_ERASE      = 8'h14;  // Mass erase
  localparam logic [7:0] CMD_WR_CFG     = 8'h1D;  // Configuration write
  localparam logic [7:0] CMD_RD_CFG     = 8'h24;  // Configuration read
  localparam logic [7:0] CMD_FETCH_PC   = 8'h28;  // fetch_program_counter_cmd
  localparam logic [7:0] CMD_STATUS     = 8'h34;  // Status read
  localparam logic [7:0] CMD_SET_BRK    = 8'h3B;  // set_breakpoint_cmd
  localparam logic [7:0] CMD_HALT       = 8'h44;  // Halt CPU
  localparam logic [7:0] CMD_RESUME     = 8'h4C;  // Resume CPU
  localparam logic [5:0] CMD_INJECT_HI  = 6'h15;  // inject_instruction_cmd upper bits
  localparam logic [7:0] CMD_STEP       = 8'h5C;  // single_step_cmd
  localparam logic [5:0] CMD_REPLACE_HI = 6'h19;  // Step-with-replacement upper bits
  localparam logic [7:0] CMD_IDENTITY   = 8'h68;  // part_identity_cmd

  // ****************************************
  // Breakpoint control byte fields
  // ****************************************
  localparam int BRK_SLOT_HI = 4;  // Slot select msb
  localparam int BRK_SLOT_LO = 3;  // Slot select lsb
  localparam int BRK_EN_BIT  = 2;  // Slot enable
  localparam int NUM_SLOTS   = 4;  // Breakpoint slots

  // ****************************************
  // Status byte fields
  // ****************************************
  localparam int ST_ERASE_DONE = 7;  // Erase complete
  localparam int ST_HALTED     = 5;  // CPU halted
  localparam int ST_LOCK       = 2;  // Debug lockout bit view

  // ****************************************
  // Reset values and states
  // ****************************************
  localparam logic [7:0] CFG_RESET = 8'h00;  // Configuration reset value

  typedef enum logic [2:0] {
    DBGCB_IDLE = 3'b000,  // Await command
    DBGCB_ARG1 = 3'b001,  // Await argument 1
    DBGCB_ARG2 = 3'b011,  // Await argument 2
    DBGCB_ARG3 = 3'b010,  // Await argument 3
    DBGCB_EXEC = 3'b110   // Run the command
  } dbgcb_state_type;

endpackage : dbgcb_pkg

// ---- design/dbgcb_shifter.sv ----
`timescale 1ns/1ps
// ****************************************
// Byte shifter for the debug link
// ****************************************
module dbgcb_shifter (
  clk,
  sys_rst,
  linkClk,
  linkDataIn,
  txLoad,
  txByte,
  rxValid,
  rxByte,
  txBit
);
  input  wire logic       clk;         // System clock
  input  wire logic       sys_rst;     // Synchronous reset
  input  wire logic       linkClk;     // Link clock, asynchronous
  input  wire logic       linkDataIn;  // Link data, asynchronous
  input  wire logic       txLoad;      // Load a reply byte
  input  wire logic [7:0] txByte;      // Reply byte
  output logic            rxValid;     // One byte received, pulse
  output logic      [7:0] rxByte;      // Received byte
  output logic            txBit;       // Current reply bit

  // Two-stage synchronisers; stage one only feeds stage two
  logic [1:0] clkSync_q, datSync_q;
  logic       clkPrev_q;              // Last synced clock
  logic [7:0] rxSh_q, rxSh_d;          // Receive shift
  logic [2:0] rxCnt_q, rxCnt_d;        // Bits received
  logic [7:0] txSh_q, txSh_d;          // Transmit shift
  logic       txArm_q, txArm_d;        // Host clocked since last load
  logic       rxValid_d;
  logic       riseEdge, fallEdge;

  assign riseEdge = clkSync_q[1] & ~clkPrev_q;
  assign fallEdge = ~clkSync_q[1] & clkPrev_q;

  // Sample on rising edge, shift reply on falling edge, MSB first
  always_comb begin
    rxSh_d    = rxSh_q;
    rxCnt_d   = rxCnt_q;
    txSh_d    = txSh_q;
    rxValid_d = 1'b0;
    txArm_d   = txArm_q;
    if (riseEdge) begin
      rxSh_d  = {rxSh_q[6:0], datSync_q[1]};
      rxCnt_d = rxCnt_q + 3'h1;
      txArm_d = 1'b1;
      if (rxCnt_q == 3'h7) begin
        rxValid_d = 1'b1;
      end
    end
    if (txLoad) begin
      // Bit 7 stands until the falling edge after the host's next rising edge; the falling edge
      // that closes the command byte must not shift it away. Holds while
      // a link half period spans at least four system clocks.
      txSh_d  = txByte;
      txArm_d = 1'b0;
    end else if (fallEdge && txArm_q) begin
      txSh_d = {txSh_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkSync_q <= 2'h0;
      datSync_q <= 2'h0;
      clkPrev_q <= 1'b0;
      rxSh_q    <= 8'h00;
      rxCnt_q   <= 3'h0;
      txSh_q    <= 8'h00;
      txArm_q   <= 1'b0;
      rxValid   <= 1'b0;
    end else begin
      clkSync_q <= {clkSync_q[0], linkClk};
      datSync_q <= {datSync_q[0], linkDataIn};
      clkPrev_q <= clkSync_q[1];
      rxSh_q    <= rxSh_d;
      rxCnt_q   <= rxCnt_d;
      txSh_q    <= txSh_d;
      txArm_q   <= txArm_d;
      rxValid   <= rxValid_d;
    end
  end

  assign rxByte = rxSh_q;
  assign txBit  = txSh_q[7];

endmodule : dbgcb_shifter

// ---- test/dbgcb_host_model.sv ----
`timescale 1ns/1ps
// ****************************************
// Debug host model
// ****************************************
module dbgcb_host_model (
  clk,
  linkClk,
  hostData,
  hostOe,
  lineLevel
);
  input  wire logic clk;        // System clock, pacing only
  output logic      linkClk;    // Link clock, still between frames
  output logic      hostData;   // Value the host drives
  output logic      hostOe;     // High while the host drives
  input  wire logic lineLevel;  // Resolved data line
  // Idle: clock low, line released
  initial begin
    linkClk  = 1'b0;
    hostData = 1'b1;
    hostOe   = 1'b0;
  end
  // Four system clocks make one link half period of 80 ns
  task automatic halfWait();
    repeat (4) @(negedge clk);
  endtask : halfWait
  // One byte out, data set while the link clock is low
  task automatic sendByte(input logic [7:0] b);
    @(negedge clk);  // Never re-drive in the step that released the line
    hostOe = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      hostData = b[i];
      halfWait();
      linkClk = 1'b1;
      halfWait();
      linkClk = 1'b0;
    end
    // Released line shows the inverse so stale data never passes
    hostData = ~b[0];
    hostOe   = 1'b0;
  endtask : sendByte
  // One byte in, sampled at the end of each high phase
  task automatic readByte(output logic [7:0] b);
    b = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      halfWait();
      linkClk = 1'b1;
      halfWait();
      b[i] = lineLevel;
      linkClk = 1'b0;
    end
  endtask : readByte
endmodule : dbgcb_host_model

// ---- test/tb_dbgcb_unit.sv ----
`timescale 1ns/1ps
// ****************************************
// Testbench for the debug command unit
// ****************************************
module tb_dbgcb_unit;
  import dbgcb_pkg::*;
  localparam logic [7:0] VER  = 8'h3C;  // Arbitrary value
  localparam logic [7:0] PART = 8'h5B;  // Arbitrary value
  logic        clk = 1'b0, sys_rst = 1'b1, linkClk, hostData, hostOe;
  logic        linkDataIn, linkDataOut, linkDataOe_n, cpuHalt, cpuStep, cpuInject;
  logic        debugLockoutBit = 1'b1, eraseDone = 1'b1, eraseStart;
  logic [15:0] cpuAddr = 16'h0000, cpuPc = 16'h0000;
  logic [1:0]  cpuInjectLen;
  logic [23:0] cpuInjectData;
  logic [7:0]  configByte, r;
  int          miscompares = 0, comparisons = 0, stepCnt = 0, injCnt = 0, eraseCnt = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  // Wire level: host wins while sending, else device, else inverse of the last host bit
  assign linkDataIn = hostOe ? hostData : (!linkDataOe_n ? linkDataOut : hostData);
  // Pulse counters, so short pulses are never missed by a late look
  always @(posedge clk) begin
    stepCnt  <= stepCnt + int'(cpuStep === 1'b1);
    injCnt   <= injCnt + int'(cpuInject === 1'b1);
    eraseCnt <= eraseCnt + int'(eraseStart === 1'b1);
  end
  dbgcb_host_model u_dbgcb_host_model (.clk(clk), .linkClk(linkClk), .hostData(hostData),
    .hostOe(hostOe), .lineLevel(linkDataIn));
  dbgcb_unit #(.PART_NUMBER(PART), .VERSION_ID(VER), .ADDR_W(16)) u_dbgcb_unit (
    .clk(clk), .sys_rst(sys_rst), .linkClk(linkClk), .linkDataIn(linkDataIn),
    .linkDataOut(linkDataOut), .linkDataOe_n(linkDataOe_n), .cpuAddr(cpuAddr),
    .cpuPc(cpuPc), .debugLockoutBit(debugLockoutBit), .eraseDone(eraseDone),
    .cpuHalt(cpuHalt), .cpuStep(cpuStep), .cpuInject(cpuInject),
    .cpuInjectLen(cpuInjectLen), .cpuInjectData(cpuInjectData),
    .eraseStart(eraseStart), .configByte(configByte));
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic cmpVal(input logic [23:0] got, input logic [23:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmpVal
  task automatic cmpCnt(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp) begin
      miscompares++;
      $display("MISMATCH %0t %s count %0d exp %0d", $time, what, got, exp);
    end
  endtask : cmpCnt
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  // Command with optional reply; reply lands in r
  task automatic cmd(input logic [7:0] c, input bit rd);
    u_dbgcb_host_model.sendByte(c);
    if (rd) begin
      u_dbgcb_host_model.readByte(r);
    end
  endtask : cmd
  // Status keeping only erase, halted and lock fields
  task automatic chkStatus(input logic h, input string what);
    cmd(CMD_STATUS, 1'b1);
    cmpVal(r & 8'hA4, {eraseDone, 1'b0, h, 2'b00, debugLockoutBit, 2'b00}, what);
  endtask : chkStatus
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic testHaltStep();
    int s;
    cmd(CMD_HALT, 1'b1);
    cmpVal(cpuHalt, 1'b1, "halt");
    chkStatus(1'b1, "status halted");
    s = stepCnt;
    cmd(CMD_STEP, 1'b1);
    cmpCnt(stepCnt - s, 1, "step");
    s = injCnt;
    cmd({CMD_INJECT_HI, 2'b01}, 1'b0);
    cmd(8'hA3, 1'b1);
    cmpCnt(injCnt - s, 1, "inject");
    cmpVal({cpuInjectLen, cpuInjectData[7:0]}, {2'b01, 8'hA3}, "inject data");
    cmd({CMD_REPLACE_HI, 2'b11}, 1'b0);
    cmd(8'h12, 1'b0);
    cmd(8'h34, 1'b0);
    cmd(8'h56, 1'b1);
    cmpVal({cpuInjectLen, cpuInjectData}, {2'b11, 24'h123456}, "replace");
    cmd(CMD_RESUME, 1'b1);
    cmpVal(cpuHalt, 1'b0, "resume");
    s = stepCnt;
    cmd(CMD_STEP, 1'b1);
    cmpCnt(stepCnt - s, 0, "step while running");
    $display("test halt_step done");
  endtask : testHaltStep
  task automatic testConfig();
    cmd(CMD_WR_CFG, 1'b0);
    cmd(8'h5A, 1'b1);
    cmpVal(configByte, 8'h5A, "config write");
    cmd(CMD_RD_CFG, 1'b1);
    cmpVal(r, 8'h5A, "config read");
    cpuPc = 16'hBEEF;
    cmd(CMD_FETCH_PC, 1'b1);
    cmpVal(r, 8'hBE, "pc high");
    u_dbgcb_host_model.readByte(r);
    cmpVal(r, 8'hEF, "pc low");
    $display("test config_pc done");
  endtask : testConfig
  // Define a slot: ignored top bits set, reserved bits 00
  task automatic setSlot(input int s, input logic en, input logic [15:0] a);
    cmd(CMD_SET_BRK, 1'b0);
    cmd({3'b111, 2'(s), en, 2'b00}, 1'b0);
    cmd(a[15:8], 1'b0);
    cmd(a[7:0], 1'b0);
  endtask : setSlot
  // Present an address and see whether the CPU is held
  task automatic hitCheck(input logic [15:0] a, input logic expHalt);
    int n;
    @(negedge clk);
    cpuAddr = a;
    for (n = 0; n < 20 && cpuHalt !== 1'b1; n++) begin
      @(negedge clk);
    end
    if (expHalt && n == 20) begin
      miscompares++;
      $display("MISMATCH %0t breakpoint never halted", $time);
    end
    cmpVal(cpuHalt, expHalt, "breakpoint");
    cpuAddr = 16'h0000;
    if (expHalt) begin
      cmd(CMD_RESUME, 1'b1);
    end
  endtask : hitCheck
  task automatic testBreak();
    for (int s = 0; s < 4; s++) begin
      setSlot(s, 1'b1, 16'h1200 + 16'(s));
    end
    hitCheck(16'h1204, 1'b0);
    for (int s = 0; s < 4; s++) begin
      hitCheck(16'h1200 + 16'(s), 1'b1);
    end
    setSlot(2, 1'b0, 16'h1202);
    hitCheck(16'h1202, 1'b0);
    hitCheck(16'h1203, 1'b1);
    $display("test breakpoint done");
  endtask : testBreak
  task automatic testLock();
    int s;
    debugLockoutBit = 1'b0;
    cmd(CMD_HALT, 1'b0);
    repeat (20) @(negedge clk);
    cmpVal(cpuHalt, 1'b0, "locked halt");
    chkStatus(1'b0, "locked status");
    cmd(CMD_IDENTITY, 1'b1);
    cmpVal(r, PART, "part number");
    u_dbgcb_host_model.readByte(r);
    cmpVal(r, VER, "identity");
    s = eraseCnt;
    eraseDone = 1'b0;
    cmd(CMD_ERASE, 1'b1);
    cmpCnt(eraseCnt - s, 1, "erase");
    chkStatus(1'b0, "erase busy");
    eraseDone = 1'b1;
    debugLockoutBit = 1'b1;
    chkStatus(1'b0, "erase done");
    $display("test lock_erase done");
  endtask : testLock
  task automatic testUnknown();
    cmd(8'hFF, 1'b0);
    repeat (20) @(negedge clk);
    cmpVal({cpuHalt, configByte}, {1'b0, 8'h5A}, "unknown code");
    chkStatus(1'b0, "after unknown");
    $display("test unknown done");
  endtask : testUnknown
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    cmpVal({cpuHalt, cpuStep, cpuInject, eraseStart, linkDataOe_n, configByte},
           {5'b00001, 8'h00}, "reset");
    repeat (4) @(negedge clk);
    $display("test reset done");
    testHaltStep();
    testConfig();
    testBreak();
    testLock();
    testUnknown();
    conclude();
  end
endmodule : tb_dbgcb_unit
